/* bsa_pkg.sv */
// Shared constants and types for the boot sequence arbiter.
// Assumes one clock domain and a synchronous active-high reset.
package bsa_pkg;

    // Default number of processor modules on the shared bus
    localparam int unsigned MOD_COUNT_DEFAULT = 4;

    // Depth of the pin synchroniser for request lines
    localparam int unsigned SYNC_STAGES = 3;

    // Arbiter states, one-hot
    typedef enum logic [2:0] {
        BSA_BOOT_PICK = 3'h1,
        BSA_BOOT_LOCK = 3'h2,
        BSA_NORMAL    = 3'h4
    } bsa_state_t;

    // Values after reset
    localparam bsa_state_t STATE_RESET     = BSA_BOOT_PICK;
    localparam logic       BOOT_MODE_RESET = 1'h1;

endpackage

/* bsa_pick_if.sv */
// Carrier between the arbiter core and its priority picker.
// Assumes both ends sit on the same clock; the picker is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface bsa_pick_if #(
    parameter int unsigned N = 4
);
    logic [N-1:0] req;
    logic [N-1:0] win;
    logic         any;

    modport core   (output req, input  win, input any);
    modport picker (input  req, output win, output any);
endinterface
`default_nettype wire

/* bsa_picker.sv */
// Fixed-priority picker: module 0 ranks highest, higher indices lower.
// Assumes the request vector is already synchronised by the caller.
`timescale 1ns/10ps
`default_nettype none
module bsa_picker
    import bsa_pkg::*;
#(
    parameter int unsigned N = MOD_COUNT_DEFAULT
) (
    bsa_pick_if.picker pk
);

    // Lowest index wins; result is one-hot or zero
    always_comb begin
        pk.win = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pk.req[i]) begin
                pk.win = '0;
                pk.win[i] = 1'b1;
            end
        end
        pk.any = |pk.req;
    end

endmodule
`default_nettype wire

/* bsa_arbiter.sv */
// Boot sequence arbiter: lets processor modules boot one at a time,
// then falls back to plain fixed-priority request/grant arbitration.
// Assumes request pins are asynchronous to ref_clk and the completion
// write port comes from bus decode logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module bsa_arbiter
    import bsa_pkg::*;
#(
    parameter int unsigned N = MOD_COUNT_DEFAULT
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] bus_request_line,
    input  wire logic         done_wr_en,
    input  wire logic [N-1:0] done_wr_data,
    output var  logic [N-1:0] bus_grant_line,
    output var  logic [N-1:0] boot_ctrl,
    output var  logic         boot_mode
);

    // Synchroniser stages and filtered requests
    logic [N-1:0] req_s1;
    logic [N-1:0] req_s2;
    logic [N-1:0] req_s3;
    logic [N-1:0] req_filt;
    logic [N-1:0] next_req_filt;

    // Arbiter state
    bsa_state_t   state;
    bsa_state_t   next_state;
    logic [N-1:0] next_grant;
    logic [N-1:0] next_done;
    logic         next_boot_mode;
    logic         set_event;

    bsa_pick_if #(.N(N)) pick ();

    bsa_picker #(.N(N)) u_picker (
        .pk (pick)
    );

    // Per-line glitch filter: a change counts once stages two and three
    // agree, so a metastable first stage never reaches the arbiter
    for (genvar g = 0; g < N; g++) begin : g_filt
        always_comb begin
            next_req_filt[g] = req_filt[g];
            if (req_s2[g] == req_s3[g]) begin
                next_req_filt[g] = req_s3[g];
            end
        end
    end

    // Synchroniser registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_s1   <= '0;
            req_s2   <= '0;
            req_s3   <= '0;
            req_filt <= '0;
        end else begin
            req_s1   <= bus_request_line;
            req_s2   <= req_s1;
            req_s3   <= req_s2;
            req_filt <= next_req_filt;
        end
    end

    // Completion bits: OR-in only, so a set can never be lost
    always_comb begin
        next_done = boot_ctrl;
        set_event = 1'b0;
        if (done_wr_en) begin
            next_done = boot_ctrl | done_wr_data;
            set_event = |(done_wr_data & ~boot_ctrl);
        end
    end

    // Finished modules drop out of the boot ranking even if they still ask;
    // a bit landing this very cycle counts too, so it is never granted
    always_comb begin
        if (state == BSA_NORMAL) begin
            pick.req = req_filt;
        end else begin
            pick.req = req_filt & ~next_done;
        end
    end

    // Next state and grant
    always_comb begin
        next_state = state;
        next_grant = bus_grant_line;
        unique case (state)
            BSA_BOOT_PICK: begin
                if (&next_done) begin
                    next_state = BSA_NORMAL;
                    next_grant = '0;
                end else if (pick.any) begin
                    next_grant = pick.win;
                    next_state = BSA_BOOT_LOCK;
                end
            end
            BSA_BOOT_LOCK: begin
                // Grant stays put whatever others request
                if (set_event) begin
                    next_grant = '0;
                    if (&next_done) begin
                        next_state = BSA_NORMAL;
                    end else begin
                        next_state = BSA_BOOT_PICK;
                    end
                end
            end
            BSA_NORMAL: begin
                // One idle cycle between owners keeps the hand-over clean
                if (bus_grant_line == '0) begin
                    if (pick.any) begin
                        next_grant = pick.win;
                    end
                end else if ((bus_grant_line & req_filt) == '0) begin
                    next_grant = '0;
                end
            end
        endcase
        next_boot_mode = (next_state != BSA_NORMAL);
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state          <= STATE_RESET;
            bus_grant_line <= '0;
            boot_ctrl      <= '0;
            boot_mode      <= BOOT_MODE_RESET;
        end else begin
            state          <= next_state;
            bus_grant_line <= next_grant;
            boot_ctrl      <= next_done;
            boot_mode      <= next_boot_mode;
        end
    end

    // Checks
    sequence s_new_bit;
        done_wr_en && ((done_wr_data & ~boot_ctrl) != '0);
    endsequence

    sequence s_locked;
        state == BSA_BOOT_LOCK;
    endsequence

    a_grant_one_hot: assert property (
        @(posedge ref_clk) disable iff (rst)
        $onehot0(bus_grant_line))
        else $error("more than one grant active");

    a_ctrl_reset_zero: assert property (
        @(posedge ref_clk)
        rst |=> (boot_ctrl == '0))
        else $error("boot control not cleared by reset");

    a_bits_sticky: assert property (
        @(posedge ref_clk) disable iff (rst)
        ((boot_ctrl & $past(boot_ctrl)) == $past(boot_ctrl)))
        else $error("completion bit cleared without reset");

    a_write_sets: assert property (
        @(posedge ref_clk) disable iff (rst)
        done_wr_en |=> ((boot_ctrl & $past(done_wr_data))
                        == $past(done_wr_data)))
        else $error("written completion bit not set");

    a_lock_holds: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_locked and !set_event |=> $stable(bus_grant_line)
                                    && (bus_grant_line != '0))
        else $error("locked boot grant moved");

    // After the idle cycle a new boot grant or normal traffic may follow
    a_release_done: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_locked and s_new_bit |=> (bus_grant_line == '0)
                                   ##1 (bus_grant_line == '0)
                                       || (state == BSA_BOOT_LOCK)
                                       || !boot_mode)
        else $error("grant not released on completion");

    a_boot_highest: assert property (
        @(posedge ref_clk) disable iff (rst)
        (state == BSA_BOOT_PICK) && pick.any && !(&next_done)
        |=> (bus_grant_line == $past(pick.win))
            && ((bus_grant_line & boot_ctrl) == '0))
        else $error("boot grant not given to top ranked requester");

    a_next_boots: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_locked and s_new_bit and !(&next_done)
        |=> (state == BSA_BOOT_PICK) && boot_mode)
        else $error("arbiter did not move on to next module");

    a_normal_entry: assert property (
        @(posedge ref_clk) disable iff (rst)
        (&boot_ctrl) |-> ##[0:1] !boot_mode)
        else $error("boot mode kept after all modules done");

    a_normal_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        (state == BSA_NORMAL) && ((bus_grant_line & req_filt) != '0)
        |=> $stable(bus_grant_line))
        else $error("normal grant dropped while still requested");

endmodule
`default_nettype wire

/* bsa_cpu_model.sv */
// Behavioural model of the processor modules sharing the bus.
// Assumes one ref_clk domain; drives at rising edges only.
`timescale 1ns/10ps
`default_nettype none
module bsa_cpu_model
    import bsa_pkg::*;
#(
    parameter int unsigned N = MOD_COUNT_DEFAULT
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] bus_grant_line,
    input  wire logic [N-1:0] boot_ctrl,
    input  wire logic         boot_mode,
    input  wire logic [N-1:0] want,
    input  wire logic [3:0]   dly,
    output var  logic [N-1:0] bus_request_line,
    output var  logic         done_wr_en,
    output var  logic [N-1:0] done_wr_data
);
    int           cnt;
    logic [3:0]   system_control_reg;

    // All modules request in boot mode, later follow the bench's wishes
    always @(posedge ref_clk) begin
        bus_request_line <= (rst || boot_mode) ? '1 : want;
        cnt <= (rst || !boot_mode || bus_grant_line == '0) ? 0 : cnt + 1;
        // Boot order is by index, so the count of done bits is our number
        if (cnt == 1) begin
            system_control_reg <= 4'($countones(boot_ctrl));
        end
        // A write of bits already set first, so no release may follow it;
        // the real completion write goes out once, even if dly jumps about
        done_wr_en <= !rst && boot_mode && (bus_grant_line != '0)
                      && (cnt == 1 || (cnt >= dly && !done_wr_en));
        // Completion bit addressed by the module's own number
        done_wr_data <= (cnt == 1) ? boot_ctrl
                                   : N'(1) << system_control_reg;
    end
endmodule
`default_nettype wire

/* bsa_arbiter_tb_top.sv */
// Self-checking bench for the boot sequence arbiter with module model.
// Assumes the package constants; two boot runs with a reset in between.
`timescale 1ns/10ps
`default_nettype none
module bsa_arbiter_tb_top;
    import bsa_pkg::*;
    localparam int N = 4;
    logic         ref_clk;
    logic         rst;
    logic         wen;
    logic         mode;
    logic         pnew;
    logic         pboot;
    logic         prst;
    logic [N-1:0] req;
    logic [N-1:0] grant;
    logic [N-1:0] ctrl;
    logic [N-1:0] wdat;
    logic [N-1:0] want;
    logic [N-1:0] pwant;
    logic [N-1:0] pg;
    logic [N-1:0] exp_done;
    logic [3:0]   dly;
    logic [31:0]  seed;
    int           err_count;
    int           comparisons;
    int           cyc;
    int           since;

    bsa_arbiter #(.N(N)) DUT (.ref_clk(ref_clk), .rst(rst),
        .bus_request_line(req), .done_wr_en(wen), .done_wr_data(wdat),
        .bus_grant_line(grant), .boot_ctrl(ctrl), .boot_mode(mode));
    bsa_cpu_model #(.N(N)) cpus (.ref_clk(ref_clk), .rst(rst),
        .bus_grant_line(grant), .boot_ctrl(ctrl), .boot_mode(mode),
        .want(want), .dly(dly), .bus_request_line(req),
        .done_wr_en(wen), .done_wr_data(wdat));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Two boot runs, each followed by random normal-mode traffic
    initial begin
        want = '0;
        dly = 4'h4;
        seed = 32'h6944FB40;
        for (int r = 0; r < 2; r++) begin
            rst <= 1'h1;
            repeat (20) @(posedge ref_clk);
            rst <= 1'h0;
            for (int k = 0; k < 640 || mode !== 1'h0; k++) begin
                @(posedge ref_clk);
                seed = lfsr(seed);
                dly <= 4'h4 + 4'(seed[2:0]);
                if (k % 32 == 31) want <= seed[N+3:4];
            end
        end
        give_verdict();
    end

    // Reference model checked at every falling edge
    always @(negedge ref_clk) begin
        cyc++;
        if (rst) begin
            exp_done = '0;
            pg = '0;
            pnew = 1'h0;
            pboot = 1'h1;
            since = 0;
            // Design clears only on the edge after it first sees reset
            if (prst) check(grant, '0);
            if (prst) check(ctrl, '0);
        end else begin
            // Leaving boot mode changes the pins just as a new wish does
            since = (want !== pwant || mode !== pboot) ? 0 : since + 1;
            check(ctrl, exp_done);
            check(N'(mode), N'(~&exp_done));
            check(grant & (grant - 1'b1), '0);
            if (pg != '0 && grant !== pg) check(grant, '0);
            if (pg != '0 && grant !== pg && pboot) check(N'(pnew), N'(1));
            if (grant != '0 && grant !== pg && mode)
                check(grant, ~exp_done & (exp_done + 1'b1));
            // A pin change needs six edges to reach the grant
            if (grant != '0 && grant !== pg && !mode && since >= 6)
                check(grant, want & (~want + 1'b1));
            if (!mode && since >= 6 && (pg & want) != '0)
                check(grant, pg);
            pnew = wen && ((wdat & ~exp_done) != '0);
            if (wen) exp_done = exp_done | wdat;
            pboot = mode;
            pg = grant;
        end
        pwant = want;
        prst = rst;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
endmodule
`default_nettype wire
